// ===== ets_pkg.sv
// Constants, register map and state types of the exposure trigger sequencer.
// Assumes a 40 MHz clock; times are held in ns and turned into cycles here, except EXP_MAX_CYC_DEF, held in cycles.
`default_nettype none

package ets_pkg;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_MHZ = 40;
  localparam int CLK_NS = 25;
  localparam int FINE_STEP_NS = 25;
  localparam int LINE_PERIOD_NS = 20000;
  localparam int EXP_MIN_NS = 1000;
  localparam int GAP1_BASE_NS = 5000;
  localparam int GAP2_BASE_NS = 5000;
  localparam int FINE_STEP_CYC = (FINE_STEP_NS + CLK_NS - 1) / CLK_NS;
  localparam int LINE_CYC = (LINE_PERIOD_NS + CLK_NS - 1) / CLK_NS;
  localparam int EXP_MIN_CYC = (EXP_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int GAP1_BASE_CYC = (GAP1_BASE_NS + CLK_NS - 1) / CLK_NS;
  localparam int GAP2_BASE_CYC = (GAP2_BASE_NS + CLK_NS - 1) / CLK_NS;
  localparam int EXP_MAX_CYC_DEF = 40000000;

  // ------------------------------------------------------------
  // Register byte offsets
  // ------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_EXPOSURE = 8'h04;
  localparam logic [7:0] OFS_POSTPONE = 8'h08;
  localparam logic [7:0] OFS_PIXEL = 8'h0C;
  localparam logic [7:0] OFS_ROI = 8'h10;
  localparam logic [7:0] OFS_SCALE = 8'h14;
  localparam logic [7:0] OFS_LINK_CAP = 8'h18;
  localparam logic [7:0] OFS_BURST = 8'h1C;
  localparam logic [7:0] OFS_GAP1 = 8'h20;
  localparam logic [7:0] OFS_SHOT2 = 8'h24;
  localparam logic [7:0] OFS_GAP2 = 8'h28;
  localparam logic [7:0] OFS_META = 8'h2C;
  localparam logic [7:0] OFS_STATUS = 8'h30;
  localparam logic [7:0] OFS_RATE = 8'h34;
  localparam logic [7:0] OFS_EXP_UPPER = 8'h38;
  localparam logic [7:0] OFS_EXP_LOWER = 8'h3C;
  localparam logic [7:0] OFS_EXP_STEP = 8'h40;
  localparam logic [7:0] OFS_EXP_ADJ = 8'h44;

  // ------------------------------------------------------------
  // Control fields and reset values
  // ------------------------------------------------------------
  localparam int CB_TRIG_ON = 0;
  localparam int CB_OVERLAP = 1;
  localparam int CB_PULSE = 2;
  localparam int CB_TWIN = 3;
  localparam int CB_PACK = 4;
  localparam int CB_ORIGIN_LO = 5;
  localparam int CB_CHUNK = 8;
  localparam int CTRL_W = 9;
  localparam logic [2:0] ORIGIN_LINE = 3'h1;
  localparam logic [CTRL_W-1:0] CTRL_RST = 9'h000;
  localparam logic [31:0] EXP_RST = 32'h00004E20;
  localparam logic [5:0] PIX_RST = 6'h08;
  localparam logic [15:0] ROI_RST = 16'h0400;
  localparam logic [7:0] BURST_RST = 8'h01;
  localparam logic [7:0] TWIN_FRAMES = 8'h02;
  localparam logic [5:0] PACK_PIX_BITS = 6'h08;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // ------------------------------------------------------------
  // Sequencer states
  // ------------------------------------------------------------
  typedef enum logic [7:0] {
    ST_IDLE = 8'h01,
    ST_DELAY = 8'h02,
    ST_EXPOSE = 8'h04,
    ST_HOLD = 8'h08,
    ST_REARM = 8'h10,
    ST_GAP1 = 8'h20,
    ST_SHOT2 = 8'h40,
    ST_GAP2 = 8'h80
  } ets_state_t;

endpackage

`default_nettype wire

// ===== ets_trig_sync.sv
// Trigger pin synchroniser with a stable-level filter and a rising-edge pulse.
// Assumes the pin is asynchronous to aclk.
`default_nettype none

module ets_trig_sync (
  input wire logic aclk, // System clock
  input wire logic aresetn, // Synchronous reset, active low
  input wire logic pin_in, // Raw trigger pin
  output logic level_out, // Filtered trigger level
  output logic rise_out // One-cycle pulse on a filtered rise
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
    logic rise;
  } ets_sync_t;

  ets_sync_t st_ff;
  ets_sync_t nxt_st;

  // Level changes only when the second and third stages agree
  always_comb begin
    nxt_st = st_ff;
    nxt_st.s1 = pin_in;
    nxt_st.s2 = st_ff.s1;
    nxt_st.s3 = st_ff.s2;
    if (st_ff.s2 == st_ff.s3) begin
      nxt_st.lvl = st_ff.s3;
    end
    nxt_st.rise = nxt_st.lvl & ~st_ff.lvl;
  end

  // Register the whole state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign level_out = st_ff.lvl;
  assign rise_out = st_ff.rise;

endmodule

`default_nettype wire

// ===== ets_sequencer.sv
// Exposure trigger sequencer: AXI4-Lite registers, exposure adjust, trigger delay,
// single/burst and twin-shot exposure sequencing, metadata and packing gates.
// Assumes transfer_busy comes from sensor logic on aclk; the trigger pin is async.
`default_nettype none

module ets_sequencer
  import ets_pkg::*;
#(
  parameter int EXP_MAX_CYC = EXP_MAX_CYC_DEF
) (
  input wire logic aclk, // System clock, 40 MHz
  input wire logic aresetn, // Synchronous reset, active low
  input wire logic [7:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write byte strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [7:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  input wire logic trigger_pin, // External trigger line
  input wire logic transfer_busy, // Sensor-to-memory transfer in progress
  input wire logic [31:0] packed_bytes, // Packed payload size of last frame
  input wire logic packed_bytes_valid, // Pulse: packed_bytes is new
  output logic expose_out, // Sensor exposure active
  output logic readout_start, // Pulse: start sensor readout
  output logic [31:0] frame_meta_exposure, // Per-frame exposure metadata
  output logic frame_meta_valid, // Pulse: metadata for a new frame
  output logic chunk_active, // Chunk metadata attached to frames
  output logic pack_active // Lossless packing in effect
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    logic aw_got;
    logic [7:0] aw_addr;
    logic w_got;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [CTRL_W-1:0] ctrl;
    logic [31:0] exp_req;
    logic [15:0] postpone_us;
    logic [5:0] pix_bits;
    logic [15:0] roi_lines;
    logic [1:0] bin_sh;
    logic [1:0] dec_sh;
    logic [31:0] link_rate_cap;
    logic [7:0] burst;
    ets_state_t st;
    logic [31:0] cnt;
    logic [7:0] left;
    logic twin_run;
    logic expose;
    logic readout;
    logic [31:0] meta;
    logic meta_valid;
    logic [31:0] rate;
  } ets_top_t;

  localparam ets_top_t TOP_RST = '{
    aw_addr: 8'h00, wdata: 32'h00000000, wstrb: 4'h0, bresp: RESP_OKAY,
    rdata: 32'h00000000, rresp: RESP_OKAY, ctrl: CTRL_RST, exp_req: EXP_RST,
    postpone_us: 16'h0000, pix_bits: PIX_RST, roi_lines: ROI_RST, bin_sh: 2'h0,
    dec_sh: 2'h0, link_rate_cap: 32'h00000000, burst: BURST_RST, st: ST_IDLE,
    cnt: 32'h00000000, left: 8'h00, meta: 32'h00000000, rate: 32'h00000000,
    default: 1'b0
  };

  ets_top_t st_ff;
  ets_top_t nxt_st;

  logic trig_lvl;
  logic trig_rise;

  // Trigger pin crosses into aclk
  ets_trig_sync u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin_in(trigger_pin),
    .level_out(trig_lvl),
    .rise_out(trig_rise)
  );

  // ------------------------------------------------------------
  // Derived configuration
  // ------------------------------------------------------------
  logic overlap_policy;
  logic triggering_on;
  logic origin_ok;
  logic twin_shot_enable;
  logic lossless_pack_enable;
  logic [31:0] exposure_step;
  logic [31:0] exposure_lower_bound;
  logic [31:0] exposure_upper_bound;
  logic [31:0] exp_clamp;
  logic [31:0] exp_adj;
  logic [31:0] readout_cyc;
  logic [31:0] first_gap_duration;
  logic [31:0] second_shot_duration;
  logic [31:0] second_gap_duration;
  logic [31:0] postpone_cyc;
  logic [7:0] frames_per_trigger;
  logic [15:0] eff_lines;
  logic [31:0] status_word;
  logic start_ok;

  assign overlap_policy = st_ff.ctrl[CB_OVERLAP];
  assign triggering_on = st_ff.ctrl[CB_TRIG_ON];
  assign origin_ok = st_ff.ctrl[CB_ORIGIN_LO +: 3] == ORIGIN_LINE;
  // Twin shot only when every precondition holds, else single/burst handling
  assign twin_shot_enable = st_ff.ctrl[CB_TWIN] & triggering_on & overlap_policy
    & origin_ok;
  assign lossless_pack_enable = st_ff.ctrl[CB_PACK] & (st_ff.pix_bits == PACK_PIX_BITS);
  assign chunk_active = st_ff.ctrl[CB_CHUNK] & ~lossless_pack_enable;
  assign pack_active = lossless_pack_enable;
  assign frames_per_trigger = twin_shot_enable ? TWIN_FRAMES : st_ff.burst;

  // Exposure step depends on the overlap policy; the bounds are fixed
  assign exposure_upper_bound = 32'(EXP_MAX_CYC);
  assign exposure_lower_bound = 32'(EXP_MIN_CYC);
  assign exposure_step = overlap_policy ? 32'(LINE_CYC) : 32'(FINE_STEP_CYC);

  // Clamp then round down to the step, staying at or above the lower bound
  always_comb begin
    exp_clamp = st_ff.exp_req;
    if (exp_clamp < exposure_lower_bound) begin
      exp_clamp = exposure_lower_bound;
    end
    if (exp_clamp > exposure_upper_bound) begin
      exp_clamp = exposure_upper_bound;
    end
    exp_adj = exp_clamp - (exp_clamp % exposure_step);
    if (exp_adj < exposure_lower_bound) begin
      exp_adj = exp_adj + exposure_step;
    end
  end

  // Readout length from ROI, scaling and pixel width
  assign eff_lines = st_ff.roi_lines >> ({1'b0, st_ff.bin_sh} + {1'b0, st_ff.dec_sh});
  assign readout_cyc = 32'(eff_lines) * 32'(LINE_CYC)
    * ((st_ff.pix_bits > PACK_PIX_BITS) ? 32'd2 : 32'd1);
  assign first_gap_duration = 32'(GAP1_BASE_CYC);
  assign second_shot_duration = readout_cyc;
  assign second_gap_duration = readout_cyc + 32'(GAP2_BASE_CYC);
  assign postpone_cyc = 32'(st_ff.postpone_us) * 32'(CLK_MHZ);

  // New exposure may start during a transfer only with readout overlap
  assign start_ok = overlap_policy | ~transfer_busy;

  assign status_word = {8'h00, frames_per_trigger, st_ff.st, 4'h0,
    chunk_active, lossless_pack_enable, twin_shot_enable, st_ff.twin_run};

  // ------------------------------------------------------------
  // Register write helper
  // ------------------------------------------------------------
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // ------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------
  always_comb begin
    logic [31:0] m;
    logic end_shot;
    m = 32'h00000000;
    end_shot = 1'b0;
    nxt_st = st_ff;
    nxt_st.readout = 1'b0;
    nxt_st.meta_valid = 1'b0;

    // Write channels: take address and data in either order
    if (s_axi_awvalid && s_axi_awready) begin
      nxt_st.aw_got = 1'b1;
      nxt_st.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      nxt_st.w_got = 1'b1;
      nxt_st.wdata = s_axi_wdata;
      nxt_st.wstrb = s_axi_wstrb;
    end
    if (st_ff.aw_got && st_ff.w_got) begin
      nxt_st.aw_got = 1'b0;
      nxt_st.w_got = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp = RESP_OKAY;
      unique case ({st_ff.aw_addr[7:2], 2'b00})
        OFS_CTRL: begin
          m = merge(32'(st_ff.ctrl), st_ff.wdata, st_ff.wstrb);
          nxt_st.ctrl = m[CTRL_W-1:0];
        end
        OFS_EXPOSURE: nxt_st.exp_req = merge(st_ff.exp_req, st_ff.wdata, st_ff.wstrb);
        OFS_POSTPONE: begin
          m = merge(32'(st_ff.postpone_us), st_ff.wdata, st_ff.wstrb);
          nxt_st.postpone_us = m[15:0];
        end
        OFS_PIXEL: begin
          m = merge(32'(st_ff.pix_bits), st_ff.wdata, st_ff.wstrb);
          nxt_st.pix_bits = m[5:0];
        end
        OFS_ROI: begin
          m = merge(32'(st_ff.roi_lines), st_ff.wdata, st_ff.wstrb);
          nxt_st.roi_lines = m[15:0];
        end
        OFS_SCALE: begin
          m = merge({28'h0000000, st_ff.dec_sh, st_ff.bin_sh}, st_ff.wdata, st_ff.wstrb);
          nxt_st.bin_sh = m[1:0];
          nxt_st.dec_sh = m[3:2];
        end
        OFS_LINK_CAP: nxt_st.link_rate_cap = merge(st_ff.link_rate_cap, st_ff.wdata,
                                                   st_ff.wstrb);
        OFS_BURST: begin
          m = merge(32'(st_ff.burst), st_ff.wdata, st_ff.wstrb);
          nxt_st.burst = (m[7:0] == 8'h00) ? BURST_RST : m[7:0];
        end
        OFS_GAP1, OFS_SHOT2, OFS_GAP2, OFS_META, OFS_STATUS, OFS_RATE, OFS_EXP_UPPER,
        OFS_EXP_LOWER, OFS_EXP_STEP, OFS_EXP_ADJ: begin
          nxt_st.bresp = RESP_OKAY; // Read-only: write ignored
        end
        default: nxt_st.bresp = RESP_DECERR;
      endcase
    end
    if (st_ff.bvalid && s_axi_bready) begin
      nxt_st.bvalid = 1'b0;
    end

    // Read channel
    if (s_axi_arvalid && s_axi_arready) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rresp = RESP_OKAY;
      unique case ({s_axi_araddr[7:2], 2'b00})
        OFS_CTRL: nxt_st.rdata = 32'(st_ff.ctrl);
        OFS_EXPOSURE: nxt_st.rdata = st_ff.exp_req;
        OFS_POSTPONE: nxt_st.rdata = 32'(st_ff.postpone_us);
        OFS_PIXEL: nxt_st.rdata = 32'(st_ff.pix_bits);
        OFS_ROI: nxt_st.rdata = 32'(st_ff.roi_lines);
        OFS_SCALE: nxt_st.rdata = {28'h0000000, st_ff.dec_sh, st_ff.bin_sh};
        OFS_LINK_CAP: nxt_st.rdata = st_ff.link_rate_cap;
        OFS_BURST: nxt_st.rdata = 32'(st_ff.burst);
        OFS_GAP1: nxt_st.rdata = first_gap_duration;
        OFS_SHOT2: nxt_st.rdata = second_shot_duration;
        OFS_GAP2: nxt_st.rdata = second_gap_duration;
        OFS_META: nxt_st.rdata = st_ff.meta;
        OFS_STATUS: nxt_st.rdata = status_word;
        OFS_RATE: nxt_st.rdata = st_ff.rate;
        OFS_EXP_UPPER: nxt_st.rdata = exposure_upper_bound;
        OFS_EXP_LOWER: nxt_st.rdata = exposure_lower_bound;
        OFS_EXP_STEP: nxt_st.rdata = exposure_step;
        OFS_EXP_ADJ: nxt_st.rdata = exp_adj;
        default: begin
          nxt_st.rdata = 32'h00000000;
          nxt_st.rresp = RESP_DECERR;
        end
      endcase
    end else if (st_ff.rvalid && s_axi_rready) begin
      nxt_st.rvalid = 1'b0;
    end

    // Packed-size rate ceiling against the link cap
    if (packed_bytes_valid && lossless_pack_enable) begin
      nxt_st.rate = (packed_bytes == 32'h00000000) ? 32'h00000000
        : st_ff.link_rate_cap / packed_bytes;
    end else if (!lossless_pack_enable) begin
      nxt_st.rate = 32'h00000000;
    end

    // Exposure sequencer
    unique case (st_ff.st)
      ST_IDLE: begin
        // Triggered start, or free run when triggering is off
        if (((triggering_on && origin_ok && trig_rise) || !triggering_on) && start_ok) begin
          nxt_st.st = ST_DELAY;
          nxt_st.cnt = triggering_on ? postpone_cyc : 32'h00000000;
          nxt_st.left = frames_per_trigger;
          nxt_st.twin_run = twin_shot_enable;
        end
      end
      ST_DELAY: begin
        if (st_ff.cnt == 32'h00000000) begin
          nxt_st.st = ST_EXPOSE;
          nxt_st.cnt = exp_adj;
          nxt_st.expose = 1'b1;
          nxt_st.meta = exp_adj;
          nxt_st.meta_valid = 1'b1;
        end else begin
          nxt_st.cnt = st_ff.cnt - 32'h00000001;
        end
      end
      ST_EXPOSE: begin
        nxt_st.cnt = st_ff.cnt - 32'h00000001;
        if (st_ff.ctrl[CB_PULSE]) begin
          end_shot = !trig_lvl || (st_ff.cnt == 32'h00000001);
        end else begin
          end_shot = st_ff.cnt == 32'h00000001;
        end
        if (end_shot) begin
          nxt_st.expose = 1'b0;
          nxt_st.st = ST_HOLD;
        end
      end
      ST_HOLD: begin
        // Readout waits for the previous transfer to finish
        if (!transfer_busy) begin
          nxt_st.readout = 1'b1;
          nxt_st.left = st_ff.left - 8'h01;
          if (st_ff.twin_run) begin
            nxt_st.st = ST_GAP1;
            nxt_st.cnt = first_gap_duration;
          end else if (st_ff.left > 8'h01) begin
            nxt_st.st = ST_REARM;
          end else begin
            nxt_st.st = ST_IDLE;
          end
        end
      end
      ST_REARM: begin
        // Next burst frame waits per overlap policy
        if (start_ok && !st_ff.readout) begin
          nxt_st.st = ST_EXPOSE;
          nxt_st.cnt = exp_adj;
          nxt_st.expose = 1'b1;
          nxt_st.meta = exp_adj;
          nxt_st.meta_valid = 1'b1;
        end
      end
      ST_GAP1: begin
        nxt_st.cnt = st_ff.cnt - 32'h00000001;
        if (st_ff.cnt <= 32'h00000001) begin
          nxt_st.st = ST_SHOT2;
          nxt_st.cnt = (second_shot_duration == 32'h00000000) ? 32'h00000001
            : second_shot_duration;
          nxt_st.expose = 1'b1;
          nxt_st.meta_valid = 1'b1;
        end
      end
      ST_SHOT2: begin
        nxt_st.cnt = st_ff.cnt - 32'h00000001;
        if (st_ff.cnt == 32'h00000001) begin
          nxt_st.expose = 1'b0;
          nxt_st.readout = 1'b1;
          nxt_st.st = ST_GAP2;
          nxt_st.cnt = second_gap_duration;
        end
      end
      ST_GAP2: begin
        nxt_st.cnt = st_ff.cnt - 32'h00000001;
        if (st_ff.cnt <= 32'h00000001) begin
          nxt_st.st = ST_IDLE;
          nxt_st.twin_run = 1'b0;
        end
      end
    endcase
  end

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff <= TOP_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Bus handshakes and outputs
  assign s_axi_awready = !st_ff.aw_got && !st_ff.bvalid;
  assign s_axi_wready = !st_ff.w_got && !st_ff.bvalid;
  assign s_axi_bvalid = st_ff.bvalid;
  assign s_axi_bresp = st_ff.bresp;
  assign s_axi_arready = !st_ff.rvalid;
  assign s_axi_rvalid = st_ff.rvalid;
  assign s_axi_rdata = st_ff.rdata;
  assign s_axi_rresp = st_ff.rresp;
  assign expose_out = st_ff.expose;
  assign readout_start = st_ff.readout;
  assign frame_meta_exposure = st_ff.meta;
  assign frame_meta_valid = st_ff.meta_valid & chunk_active;

endmodule

`default_nettype wire

// ===== ets_sva.sv
// Port checker for the exposure trigger sequencer.
// Assumes it is bound to ets_sequencer and connected by name.
`default_nettype none
module ets_sva #(parameter int EXP_MAX_CYC = 4000) (
  input wire logic aclk, // Clock
  input wire logic aresetn, // Reset, active low
  input wire logic s_axi_arvalid, // Read request
  input wire logic s_axi_arready, // Read ready
  input wire logic s_axi_rvalid, // Read answer
  input wire logic s_axi_bvalid, // Write answer
  input wire logic s_axi_awready, // Write ready
  input wire logic transfer_busy, // Transfer running
  input wire logic expose_out, // Exposure
  input wire logic readout_start, // Readout pulse
  input wire logic frame_meta_valid, // Metadata pulse
  input wire logic chunk_active, // Chunk data on
  input wire logic pack_active // Packing on
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  int exp_cnt_ff;
  // Length of the running exposure
  always_ff @(posedge aclk) exp_cnt_ff <= (!aresetn || !expose_out) ? 0 : exp_cnt_ff + 1;
  sequence ar_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  a_exp_cap: assert property (exp_cnt_ff <= EXP_MAX_CYC) else $error("exposure too long");
  a_no_chunk_pack: assert property (pack_active |-> !chunk_active) else $error("chunk on");
  a_meta_gated: assert property (frame_meta_valid |-> chunk_active) else $error("meta");
  a_meta_start: assert property ($rose(expose_out) && chunk_active |-> frame_meta_valid)
    else $error("no meta at exposure start");
  a_readout_free: assert property (readout_start |-> !$past(transfer_busy))
    else $error("readout during transfer");
  a_readout_pulse: assert property (readout_start |=> !readout_start) else $error("long");
  a_rd_answer: assert property (ar_taken |=> s_axi_rvalid) else $error("read answer late");
  a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("ar taken");
  a_aw_block: assert property (s_axi_bvalid |-> !s_axi_awready) else $error("aw taken");
endmodule
`default_nettype wire

// ===== ets_partner.sv
// Trigger source and sensor transfer model.
// Assumes readout_start pulses once per frame transfer.
`default_nettype none
module ets_partner #(parameter int XFER = 500) (
  input wire logic aclk, // Clock
  input wire logic readout_start, // Transfer start
  output logic trigger_pin, // Trigger line
  output logic transfer_busy // Transfer running
);
  timeunit 1ns;
  timeprecision 1ps;
  int left = 0;
  initial trigger_pin = 1'b0;
  // Trigger pulse of w cycles
  task automatic fire(input int w);
    @(posedge aclk);
    trigger_pin <= 1'b1;
    repeat (w) @(posedge aclk);
    trigger_pin <= 1'b0;
  endtask
  // Each transfer keeps the sensor busy for XFER cycles
  always @(posedge aclk) begin
    if (readout_start) left <= XFER;
    else if (left > 0) left <= left - 1;
  end
  assign transfer_busy = left > 0;
endmodule
`default_nettype wire

// ===== tb.sv
// Self-checking bench for the exposure trigger sequencer.
// Assumes ets_pkg, ets_sequencer, ets_partner and ets_sva are compiled first.
`default_nettype none
module tb;
  import ets_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int MAXC = 4000;
  logic aclk, aresetn, awv, wv, brdy, arv, rrdy, pbv, awr, wr_, bv, arr, rvl, trig, busy;
  logic expo, ro, mv, ca, pa;
  logic [7:0] awa, ara;
  logic [31:0] wd, pb, rv, rdata, meta;
  logic [1:0] rr, rs, bresp, bs;
  int err_total, num_checks, cnt, wid, n_exp, n_ro, d, e, r;
  logic [31:0] seed = 269;
  ets_sequencer #(.EXP_MAX_CYC(MAXC)) dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr_), .s_axi_bresp(bresp),
    .s_axi_bvalid(bv), .s_axi_bready(brdy), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rs), .s_axi_rvalid(rvl),
    .s_axi_rready(rrdy), .trigger_pin(trig), .transfer_busy(busy), .packed_bytes(pb),
    .packed_bytes_valid(pbv), .expose_out(expo), .readout_start(ro),
    .frame_meta_exposure(meta), .frame_meta_valid(mv), .chunk_active(ca), .pack_active(pa));
  ets_partner p (.aclk(aclk), .readout_start(ro), .trigger_pin(trig), .transfer_busy(busy));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Expected clamped and rounded exposure
  function automatic int adj(int v, int s);
    int q;
    q = v < EXP_MIN_CYC ? EXP_MIN_CYC : (v > MAXC ? MAXC : v);
    q = q / s * s;
    return q < EXP_MIN_CYC ? q + s : q;
  endfunction
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
    num_checks++;
    if (s !== x) begin
      err_total++;
      $display("unexpected %s: expected %0h seen %0h", n, x, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic ta, tw, tb_;
    {awa, wd, awv, wv, brdy} <= {a, v, 3'b111};
    do begin
      @(negedge aclk);
      {ta, tw, tb_, bs} = {awr, wr_, bv, bresp};
      @(posedge aclk);
      if (ta) awv <= 1'b0;
      if (tw) wv <= 1'b0;
    end while (!tb_);
    brdy <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rd(input logic [7:0] a);
    logic ta, tr;
    {ara, arv, rrdy} <= {a, 2'b11};
    do begin
      @(negedge aclk);
      {ta, tr, rv, rr} = {arr, rvl, rdata, rs};
      @(posedge aclk);
      if (ta) arv <= 1'b0;
    end while (!tr);
    rrdy <= 1'b0;
    @(posedge aclk);
  endtask
  // Waits 5000 cycles, fires a trigger and counts cycles to exposure
  task automatic pulse(input int w);
    repeat (5000) @(posedge aclk);
    fork p.fire(w); join_none
    d = 0;
    while (!expo && d < 2000) begin
      @(negedge aclk);
      d++;
    end
    repeat (500) @(posedge aclk);
  endtask
  task automatic finish_test();
    if (err_total == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Exposure width and frame counters
  always @(negedge aclk) begin
    cnt <= expo ? cnt + 1 : 0;
    if (!expo && cnt > 0) wid <= cnt;
    if (expo && cnt == 0) n_exp <= n_exp + 1;
    if (ro) n_ro <= n_ro + 1;
  end
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  initial begin
    repeat (100000) @(posedge aclk);
    err_total++;
    finish_test();
  end
  initial begin
    {aresetn, awv, wv, brdy, arv, rrdy, pbv, awa, ara, wd, pb} = '0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(OFS_EXPOSURE);
    chk("exp reset", rv, EXP_RST);
    rd(8'h48);
    chk("unmapped", rv, 32'h0);
    chk("unmapped resp", 32'(rr), 32'(RESP_DECERR));
    wr(8'h48, 32'h0);
    chk("unmapped wr", 32'(bs), 32'(RESP_DECERR));
    // Step, bound and rounding under both overlap policies
    for (int o = 0; o < 2; o++) begin
      wr(OFS_CTRL, 32'(o << 1));
      rd(OFS_EXP_STEP);
      chk("step", rv, o ? LINE_CYC : FINE_STEP_CYC);
      rd(OFS_EXP_UPPER);
      chk("upper", rv, MAXC);
      repeat (4) begin
        d = rnd() % 5000;
        wr(OFS_EXPOSURE, d);
        rd(OFS_EXP_ADJ);
        chk("adjusted", rv, adj(d, o ? LINE_CYC : FINE_STEP_CYC));
      end
    end
    // Packing gate, chunk data and rate ceiling
    wr(OFS_CTRL, 32'h110);
    wr(OFS_PIXEL, 32'hA);
    chk("pack", {pa, ca}, 2'h1);
    wr(OFS_PIXEL, 32'h8);
    chk("pack", {pa, ca}, 2'h2);
    wr(OFS_LINK_CAP, 32'h3B9ACA0);
    pb <= rnd() % 5000 + 1;
    pbv <= 1'b1;
    @(posedge aclk);
    pbv <= 1'b0;
    repeat (40) @(posedge aclk);
    rd(OFS_RATE);
    chk("rate", rv, 32'h3B9ACA0 / pb);
    // Timed and pulse-length exposures
    wr(OFS_POSTPONE, 32'h1);
    wr(OFS_EXPOSURE, 32'h64);
    wr(OFS_CTRL, 32'h121);
    pulse(300);
    chk("delay", 32'(d >= 42 && d <= 50), 1);
    chk("timed", wid, 100);
    wr(OFS_POSTPONE, 32'h0);
    wr(OFS_CTRL, 32'h125);
    pulse(300);
    chk("capped", wid, 100);
    chk("pulse meta", meta, 100);
    pulse(20);
    chk("width", 32'(wid >= 17 && wid <= 22), 1);
    // Twin shot sequence
    wr(OFS_ROI, 32'h1);
    wr(OFS_EXPOSURE, 32'h320);
    wr(OFS_GAP1, 32'h5);
    wr(OFS_CTRL, 32'h12B);
    rd(OFS_GAP1);
    chk("gap1", rv, GAP1_BASE_CYC);
    rd(OFS_SHOT2);
    chk("shot2", rv, LINE_CYC);
    rd(OFS_GAP2);
    chk("gap2", rv, LINE_CYC + GAP2_BASE_CYC);
    rd(OFS_STATUS);
    chk("twin on", {rv[23:16], rv[1]}, {8'h2, 1'b1});
    {e, r} = {n_exp, n_ro};
    pulse(10);
    repeat (900) @(posedge aclk);
    fork p.fire(10); join_none
    repeat (3000) @(posedge aclk);
    chk("frames", n_exp - e, 2);
    chk("readouts", n_ro - r, 2);
    chk("twin meta", meta, 32'h320);
    wr(OFS_CTRL, 32'h29);
    rd(OFS_STATUS);
    chk("twin off", {rv[23:16], rv[1]}, {8'h1, 1'b0});
    wr(OFS_CTRL, 32'h0B);
    rd(OFS_STATUS);
    chk("twin off", {rv[23:16], rv[1]}, {8'h1, 1'b0});
    wr(OFS_ROI, 32'h40);
    wr(OFS_SCALE, 32'hF);
    rd(OFS_SHOT2);
    chk("scaled shot2", rv, LINE_CYC);
    finish_test();
  end
endmodule
bind ets_sequencer ets_sva #(.EXP_MAX_CYC(EXP_MAX_CYC)) u_sva (.*);
`default_nettype wire
